// ==== design/slow_clock_timebase.sv ====
// slow-clock timebase: real-time counter, periodic interrupt, watchdog, cpu clock control
`timescale 1ns/100ps
module slow_clock_timebase
  import timebase_pkg::*;
#(
  parameter int unsigned WDOG_LIMIT = WDOG_TICKS
)(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic slow_tick_in,
  input wire clk_ctrl_t clk_ctrl_in,
  input wire logic wdog_hit_in,
  output logic [RTC_WIDTH-1:0] rtc_count_out,
  output timebase_evt_t evt_out,
  output logic [3:0] cpu_div_out,
  output logic cpu_doubler_out,
  output logic cpu_on_slow_out,
  output logic cpu_clk_en_out
);

  // ----------------------------------------
  // slow tick edge
  // ----------------------------------------
  // slow_tick_in is taken as a synchronous level from the 32.768 kHz source
  logic tick_prev_q;
  wire slow_edge = slow_tick_in & ~tick_prev_q;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      tick_prev_q <= 1'b0;
    else
      tick_prev_q <= slow_tick_in;
  end

  // ----------------------------------------
  // real-time counter
  // ----------------------------------------
  logic [RTC_WIDTH-1:0] rtc_q;
  wire [RTC_WIDTH-1:0] rtc_d = rtc_q + {{(RTC_WIDTH-1){1'b0}}, 1'b1};

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      rtc_q <= '0;
    else if (slow_edge)
      rtc_q <= rtc_d;
  end
  assign rtc_count_out = rtc_q;

  // ----------------------------------------
  // periodic interrupt
  // ----------------------------------------
  logic [3:0] per_cnt_q;
  logic per_irq_q;
  wire on_slow = (clk_ctrl_in.sel == CPU_CLK_SLOW);
  wire per_wrap = slow_edge && (per_cnt_q == 4'(PERIODIC_DIV - 1));

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      per_cnt_q <= 4'h0;
      per_irq_q <= 1'b0;
    end
    else
    begin
      if (slow_edge)
        per_cnt_q <= per_cnt_q + 4'h1;
      per_irq_q <= per_wrap && !on_slow;
    end
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // a hit in the same cycle as a tick wins, so service is never lost
  logic [WDOG_WIDTH-1:0] wdog_q;
  logic wdog_rst_q;
  wire wdog_expire = slow_edge && (wdog_q == WDOG_WIDTH'(WDOG_LIMIT - 1));

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      wdog_q <= '0;
      wdog_rst_q <= 1'b0;
    end
    else
    begin
      if (wdog_hit_in || wdog_expire)
        wdog_q <= '0;
      else if (slow_edge)
        wdog_q <= wdog_q + WDOG_WIDTH'(1);
      wdog_rst_q <= wdog_expire && !wdog_hit_in;
    end
  end

  assign evt_out = '{periodic_irq: per_irq_q, wdog_reset: wdog_rst_q};

  // ----------------------------------------
  // cpu clock control
  // ----------------------------------------
  logic [3:0] div_q;
  logic [3:0] div_cnt_q;
  logic dbl_q;
  logic slow_q;
  logic en_q;
  wire [3:0] div_sel = (clk_ctrl_in.sel == CPU_CLK_MAIN_DIV) ? clk_ctrl_in.div : 4'h0;
  wire div_done = (div_cnt_q >= div_q);

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      div_q <= 4'h0;
      div_cnt_q <= 4'h0;
      dbl_q <= 1'b0;
      slow_q <= 1'b0;
      en_q <= 1'b0;
    end
    else
    begin
      div_q <= div_sel;
      dbl_q <= (clk_ctrl_in.sel == CPU_CLK_DOUBLED);
      slow_q <= on_slow;
      if (on_slow)
      begin
        en_q <= slow_edge;
        div_cnt_q <= 4'h0;
      end
      else if (div_done)
      begin
        en_q <= 1'b1;
        div_cnt_q <= 4'h0;
      end
      else
      begin
        en_q <= 1'b0;
        div_cnt_q <= div_cnt_q + 4'h1;
      end
    end
  end

  assign cpu_div_out = div_q;
  assign cpu_doubler_out = dbl_q;
  assign cpu_on_slow_out = slow_q;
  assign cpu_clk_en_out = en_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_wrap_main;
    per_wrap && !on_slow;
  endsequence

  property p_rtc_step;
    @(posedge clk_sys_in) disable iff (rst_in)
    slow_edge |=> rtc_q == $past(rtc_q) + 48'h1;
  endproperty
  a_rtc_step: assert property (p_rtc_step) else $error("rtc did not step");

  property p_rtc_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
    !slow_edge |=> $stable(rtc_q);
  endproperty
  a_rtc_hold: assert property (p_rtc_hold) else $error("rtc moved without tick");

  property p_per_irq;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_wrap_main |=> evt_out.periodic_irq;
  endproperty
  a_per_irq: assert property (p_per_irq) else $error("periodic irq missing");

  property p_per_suppress;
    @(posedge clk_sys_in) disable iff (rst_in)
    on_slow |=> !evt_out.periodic_irq;
  endproperty
  a_per_suppress: assert property (p_per_suppress) else $error("irq while on slow clock");

  property p_per_cause;
    @(posedge clk_sys_in) disable iff (rst_in)
    evt_out.periodic_irq |-> $past(per_cnt_q) == 4'hf && $past(slow_edge);
  endproperty
  a_per_cause: assert property (p_per_cause) else $error("irq not on 16th tick");

  property p_rtc_on_slow;
    @(posedge clk_sys_in) disable iff (rst_in)
    on_slow && slow_edge |=> rtc_q != $past(rtc_q);
  endproperty
  a_rtc_on_slow: assert property (p_rtc_on_slow) else $error("rtc stalled on slow clock");

  property p_wdog_fire;
    @(posedge clk_sys_in) disable iff (rst_in)
    evt_out.wdog_reset |-> $past(wdog_q) == WDOG_WIDTH'(WDOG_LIMIT - 1) && !$past(wdog_hit_in);
  endproperty
  a_wdog_fire: assert property (p_wdog_fire) else $error("watchdog fired early");

  property p_wdog_hit;
    @(posedge clk_sys_in) disable iff (rst_in)
    wdog_hit_in |=> wdog_q == '0 ##1 !evt_out.wdog_reset;
  endproperty
  a_wdog_hit: assert property (p_wdog_hit) else $error("hit did not clear watchdog");

  property p_slow_en;
    @(posedge clk_sys_in) disable iff (rst_in)
    on_slow && !slow_edge |=> !cpu_clk_en_out;
  endproperty
  a_slow_en: assert property (p_slow_en) else $error("cpu enable off slow tick");

endmodule : slow_clock_timebase

// ==== design/timebase_pkg.sv ====
// package: constants and types for the slow-clock timebase
package timebase_pkg;

  // ----------------------------------------
  // clock rates and timing
  // ----------------------------------------
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  localparam int unsigned SLOW_CLK_HZ = 32_768;
  localparam int unsigned RTC_WIDTH = 48;
  localparam int unsigned PERIODIC_DIV = 16;
  localparam int unsigned PERIODIC_US = 488;
  localparam int unsigned WDOG_TIMEOUT_S = 2;
  localparam int unsigned WDOG_TICKS = WDOG_TIMEOUT_S * SLOW_CLK_HZ;
  localparam int unsigned WDOG_WIDTH = 17;

  // ----------------------------------------
  // processor clock selection
  // ----------------------------------------
  typedef enum logic [1:0] {
    CPU_CLK_MAIN = 2'h0,
    CPU_CLK_MAIN_DIV = 2'h1,
    CPU_CLK_DOUBLED = 2'h2,
    CPU_CLK_SLOW = 2'h3
  } cpu_clk_sel_t;

  localparam logic [3:0] DIV_MAX = 4'hf;

  typedef struct packed {
    cpu_clk_sel_t sel;
    logic [3:0] div;
  } clk_ctrl_t;

  typedef struct packed {
    logic periodic_irq;
    logic wdog_reset;
  } timebase_evt_t;

endpackage : timebase_pkg

// ==== testbench/core_irq_model.sv ====
// partner: core that services the watchdog from its periodic interrupt
`timescale 1ns/100ps
module core_irq_model
  import timebase_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire timebase_evt_t evt_in,
  input wire logic hit_en_in,
  output logic wdog_hit_out
);
  initial wdog_hit_out = 1'b0;
  // the interrupt routine hits one cycle after each interrupt; disabled to starve it
  always @(posedge clk_sys_in)
  begin
    wdog_hit_out <= #10 !rst_in && hit_en_in && evt_in.periodic_irq;
  end
endmodule : core_irq_model

// ==== testbench/test_slow_clock_timebase.sv ====
// testbench: slow-tick driver, queued counter checks, interrupt and watchdog counts
`timescale 1ns/100ps
module test_slow_clock_timebase;
  import timebase_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic slow_tick_in = 1'b0;
  clk_ctrl_t clk_ctrl_in = '0;
  logic wdog_hit_in;
  logic hit_en = 1'b1;
  logic [RTC_WIDTH-1:0] rtc_count_out;
  timebase_evt_t evt_out;
  logic [3:0] cpu_div_out;
  logic cpu_doubler_out;
  logic cpu_on_slow_out;
  logic cpu_clk_en_out;
  logic [47:0] exp_q[$];
  logic [47:0] exp_rtc = '0;
  logic [47:0] last_rtc = '0;
  int err_total = 0;
  int n_compared = 0;
  int irq_seen = 0;
  int wdog_seen = 0;
  int en_cnt = 0;
  int per_len = 1;
  int seed = 21;

  always #50 clk_sys_in = ~clk_sys_in;

  // short watchdog limit keeps the starvation phase brief
  slow_clock_timebase #(.WDOG_LIMIT(20)) slow_clock_timebase_inst (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .slow_tick_in(slow_tick_in),
    .clk_ctrl_in(clk_ctrl_in), .wdog_hit_in(wdog_hit_in), .rtc_count_out(rtc_count_out),
    .evt_out(evt_out), .cpu_div_out(cpu_div_out), .cpu_doubler_out(cpu_doubler_out),
    .cpu_on_slow_out(cpu_on_slow_out), .cpu_clk_en_out(cpu_clk_en_out));
  core_irq_model core_irq_model_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .evt_in(evt_out), .hit_en_in(hit_en), .wdog_hit_out(wdog_hit_in));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // one slow tick under a given selection, random spacing of at least two low cycles
  task automatic tick(input int sel);
    int gap;
    logic [3:0] dv;
    gap = 2 + ($unsigned($random(seed)) % 4);
    dv = 4'($random(seed));
    clk_ctrl_in.sel = cpu_clk_sel_t'(sel);
    clk_ctrl_in.div = dv;
    slow_tick_in = 1'b1;
    exp_rtc = exp_rtc + 48'h1;
    exp_q.push_back(exp_rtc);
    @(posedge clk_sys_in) #10;
    if (sel == 3)
      check(48'(cpu_clk_en_out), 48'h1);
    slow_tick_in = 1'b0;
    repeat (gap) @(posedge clk_sys_in) #10;
    check({42'h0, cpu_div_out, cpu_doubler_out, cpu_on_slow_out},
      {42'h0, (sel == 1) ? dv : 4'h0, sel == 2, sel == 3});
    // undivided selections enable every cycle; on the slow clock only right after a tick
    if (sel != 1)
      check(48'(cpu_clk_en_out), 48'(sel == 0 || sel == 2));
  endtask : tick

  // ----------------------------------------
  // output watcher
  // ----------------------------------------
  always @(negedge clk_sys_in)
  begin
    if (!rst_in && rtc_count_out !== last_rtc)
    begin
      last_rtc = rtc_count_out;
      if (exp_q.size() == 0)
        check(rtc_count_out, ~rtc_count_out);
      else
        check(rtc_count_out, exp_q.pop_front());
    end
    irq_seen += (evt_out.periodic_irq === 1'b1);
    wdog_seen += (evt_out.wdog_reset === 1'b1);
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    err_total++;
    final_report();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_sys_in);
    #10 rst_in = 1'b0;
    for (int i = 0; i < 48; i++) tick(i % 3);
    hit_en = 1'b0;
    for (int i = 0; i < 40; i++) tick(3);
    hit_en = 1'b1;
    for (int i = 0; i < 16; i++) tick(0);
    repeat (4) @(posedge clk_sys_in);
    check(48'(irq_seen), 48'h4);
    check(48'(wdog_seen), 48'h2);
    check(48'(exp_q.size()), 48'h0);
    // divided clock: any window of sixteen whole periods holds exactly sixteen enables
    #10;
    clk_ctrl_in.div = 4'($random(seed));
    clk_ctrl_in.sel = CPU_CLK_MAIN_DIV;
    per_len = int'(clk_ctrl_in.div) + 1;
    repeat (20) @(posedge clk_sys_in) #10;
    for (int i = 0; i < 16 * per_len; i++)
    begin
      en_cnt += (cpu_clk_en_out === 1'b1);
      @(posedge clk_sys_in) #10;
    end
    check(48'(en_cnt), 48'h10);
    final_report();
  end
endmodule : test_slow_clock_timebase
